/* hdl/sghbp_clock_divider.sv */
/*
  Master clock tick: every cycle, or every second cycle when dividing.
  Assumes divide_select is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
module sghbp_clock_divider (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic divide_select,
  output logic      master_tick
);

  logic phase;

  // ---------------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------------
  // a tick enable instead of a gated clock keeps one clock domain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= sghbp_pkg::DIVIDE_PHASE_RESET;
    end else begin
      phase <= !phase;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_tick <= sghbp_pkg::TICK_RESET;
    end else begin
      master_tick <= divide_select ? 1'b1 : phase;
    end
  end

  full_rate_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) divide_select |=> master_tick)
    else $error("master tick missing at full rate");

  half_rate_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    (!divide_select) [*2] |=> master_tick != $past(master_tick))
    else $error("master tick not alternating when dividing");

endmodule

/* hdl/sghbp_mode_decode.sv */
/*
  Bus control decoder: three control lines to one of four bus modes.
  Assumes the code comes from logic on the same clock.
*/
`timescale 1ns/1ps
module sghbp_mode_decode (
  input  wire logic [2:0]              bus_code,
  output sghbp_pkg::sghbp_mode_type    mode
);

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  // unused codes are legal and mean inactive
  always_comb begin
    unique case (bus_code)
      sghbp_pkg::CODE_ADDR_A,
      sghbp_pkg::CODE_ADDR_B,
      sghbp_pkg::CODE_ADDR_C: mode = sghbp_pkg::MODE_ADDRESS;
      sghbp_pkg::CODE_READ:   mode = sghbp_pkg::MODE_READ;
      sghbp_pkg::CODE_WRITE:  mode = sghbp_pkg::MODE_WRITE;
      default:                mode = sghbp_pkg::MODE_INACTIVE;
    endcase
  end

endmodule

/* hdl/sghbp_top.sv */
/*
  Host bus port of a three channel sound generator: bus mode decode,
  chip select, register index latch, sixteen entry register array,
  i/o port direction, master clock tick and board i/o port decode.
  Assumes all inputs are asynchronous pins; the bus wire is resolved
  outside from bus_out and bus_oe.
*/
`timescale 1ns/1ps
// Overview of operation
// - code 001,100,111 address; 011 read; 110 write; others inactive.
// - inactive mode leaves the bus undriven and changes no register.
// - address mode reads the bus and latches a new register index.
// - write mode stores the bus value into the indexed register.
// - read mode drives the bus with the indexed register.
// - index accepted only with top nibble zero and, on pin cycles, upper select high, low.
// - low nibble is the index; top nibble and selects form chip address.
// - bus bits map one to one onto register bits.
// - active low reset clears all sixteen registers to zero.
// - master clock is input clock when select high, half when low.
// - select port at CF or DF, data port at 0F or 1F, any pairing.
// - host writes index to select port, then data to data port.
// - host reads port A: select register 14, then read select port.
// - latched index holds until the next address mode fetch.
// - a chip address mismatch keeps the bus undriven.
// - register 7 bits 7 and 6 set port B and A direction, one output.
module sghbp_top (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       bus_direction,
  input  wire logic       bus_ctrl_high,
  input  wire logic       bus_ctrl_low,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] bus_out,
  output logic            bus_oe,
  input  wire logic       upper_select_high,
  input  wire logic       upper_select_low,
  input  wire logic       clock_divide_select,
  output logic            master_tick,
  input  wire logic [7:0] port_a_pins,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  input  wire logic [7:0] port_b_pins,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  input  wire logic [7:0] host_port_addr,
  input  wire logic       host_write,
  input  wire logic       host_read,
  input  wire logic [7:0] host_data,
  output logic      [7:0] host_read_data,
  output logic      [3:0] register_index
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [sghbp_pkg::SYNC_W-1:0] sync_in;
  logic [sghbp_pkg::SYNC_W-1:0] sync_meta;
  logic [sghbp_pkg::SYNC_W-1:0] sync_stable;

  assign sync_in = {bus_direction, bus_ctrl_high, bus_ctrl_low, bus_in,
                    upper_select_high, upper_select_low,
                    clock_divide_select, port_a_pins, port_b_pins,
                    host_port_addr, host_write, host_read, host_data};

  // meta stage feeds the stable stage only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_meta   <= '0;
      sync_stable <= '0;
    end else begin
      sync_meta   <= sync_in;
      sync_stable <= sync_meta;
    end
  end

  logic [2:0] pin_code;
  logic [7:0] s_bus_in;
  logic       s_upper_high;
  logic       s_upper_low;
  logic       s_divide_select;
  logic [7:0] s_port_a;
  logic [7:0] s_port_b;
  logic [7:0] s_host_addr;
  logic       s_host_write;
  logic       s_host_read;
  logic [7:0] s_host_data;

  assign {pin_code, s_bus_in, s_upper_high, s_upper_low, s_divide_select,
          s_port_a, s_port_b, s_host_addr, s_host_write, s_host_read,
          s_host_data} = sync_stable;

  // ---------------------------------------------------------------------
  // board i/o port decode
  // ---------------------------------------------------------------------
  logic       select_hit;
  logic       data_hit;
  logic [2:0] host_code;

  assign select_hit = (s_host_addr == sghbp_pkg::SELECT_PORT_0) ||
                      (s_host_addr == sghbp_pkg::SELECT_PORT_1);
  assign data_hit   = (s_host_addr == sghbp_pkg::DATA_PORT_0) ||
                      (s_host_addr == sghbp_pkg::DATA_PORT_1);

  always_comb begin
    host_code = sghbp_pkg::CODE_IDLE;
    if (s_host_write && select_hit) begin
      host_code = sghbp_pkg::CODE_ADDR_A;
    end else if (s_host_write && data_hit) begin
      host_code = sghbp_pkg::CODE_WRITE;
    end else if (s_host_read && select_hit) begin
      host_code = sghbp_pkg::CODE_READ;
    end
  end

  // ---------------------------------------------------------------------
  // bus mode
  // ---------------------------------------------------------------------
  sghbp_pkg::sghbp_mode_type pin_mode;
  sghbp_pkg::sghbp_mode_type host_mode;
  sghbp_pkg::sghbp_mode_type mode;
  logic                      host_active;
  logic [7:0]                bus_value;
  logic [3:0]                index_candidate;
  logic                      upper_ok;
  logic                      upper_match;

  sghbp_mode_decode pin_decode (
    .bus_code (pin_code),
    .mode     (pin_mode)
  );

  sghbp_mode_decode host_decode (
    .bus_code (host_code),
    .mode     (host_mode)
  );

  // host access wins and skips the upper select check; only the top nibble must match
  assign host_active = host_mode != sghbp_pkg::MODE_INACTIVE;
  assign mode        = host_active ? host_mode : pin_mode;
  assign bus_value   = host_active ? s_host_data : s_bus_in;
  assign index_candidate = bus_value[3:0];
  assign upper_ok    = host_active ||
                       ((s_upper_high == sghbp_pkg::UPPER_HIGH_MATCH) &&
                        (s_upper_low == sghbp_pkg::UPPER_LOW_MATCH));
  assign upper_match = upper_ok &&
                       (bus_value[7:4] == sghbp_pkg::CHIP_UPPER);

  // ---------------------------------------------------------------------
  // index latch and chip select
  // ---------------------------------------------------------------------
  logic chip_selected;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      register_index <= sghbp_pkg::INDEX_RESET;
    end else if (mode == sghbp_pkg::MODE_ADDRESS && upper_match) begin
      register_index <= index_candidate;
    end
  end

  // a foreign address deselects until the next matching fetch
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_selected <= sghbp_pkg::SELECT_RESET;
    end else if (mode == sghbp_pkg::MODE_ADDRESS) begin
      chip_selected <= upper_match;
    end
  end

  // ---------------------------------------------------------------------
  // register array
  // ---------------------------------------------------------------------
  logic [7:0] regs [sghbp_pkg::REG_COUNT];
  logic       write_enable;

  assign write_enable = (mode == sghbp_pkg::MODE_WRITE) && chip_selected;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < sghbp_pkg::REG_COUNT; i++) begin
        regs[i] <= sghbp_pkg::REG_RESET;
      end
    end else if (write_enable) begin
      regs[register_index] <= bus_value;
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  logic       dir_a_out;
  logic       dir_b_out;
  logic [7:0] read_value;
  logic       pin_read;
  logic       host_read_hit;

  assign dir_a_out = regs[sghbp_pkg::INDEX_MIXER_IO][sghbp_pkg::DIR_A_BIT];
  assign dir_b_out = regs[sghbp_pkg::INDEX_MIXER_IO][sghbp_pkg::DIR_B_BIT];

  // input ports return the pins, output ports their latch
  always_comb begin
    read_value = regs[register_index];
    if (register_index == sghbp_pkg::INDEX_PORT_A && !dir_a_out) begin
      read_value = s_port_a;
    end else if (register_index == sghbp_pkg::INDEX_PORT_B && !dir_b_out) begin
      read_value = s_port_b;
    end
  end

  assign pin_read = (mode == sghbp_pkg::MODE_READ) && chip_selected &&
                    !host_active;
  assign host_read_hit = (host_mode == sghbp_pkg::MODE_READ) && chip_selected;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_oe  <= 1'b0;
      bus_out <= sghbp_pkg::REG_RESET;
    end else begin
      bus_oe  <= pin_read;
      bus_out <= read_value;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_read_data <= sghbp_pkg::REG_RESET;
    end else if (host_read_hit) begin
      host_read_data <= read_value;
    end
  end

  // ---------------------------------------------------------------------
  // i/o ports
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_out <= sghbp_pkg::REG_RESET;
      port_b_out <= sghbp_pkg::REG_RESET;
      port_a_oe  <= '0;
      port_b_oe  <= '0;
    end else begin
      port_a_out <= regs[sghbp_pkg::INDEX_PORT_A];
      port_b_out <= regs[sghbp_pkg::INDEX_PORT_B];
      port_a_oe  <= {8{dir_a_out}};
      port_b_oe  <= {8{dir_b_out}};
    end
  end

  // ---------------------------------------------------------------------
  // master clock
  // ---------------------------------------------------------------------
  sghbp_clock_divider divider (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .divide_select (s_divide_select),
    .master_tick   (master_tick)
  );

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  logic [127:0] regs_flat;

  always_comb begin
    regs_flat = '0;
    for (int i = 0; i < sghbp_pkg::REG_COUNT; i++) begin
      regs_flat[i*8 +: 8] = regs[i];
    end
  end

  mode_decode_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (!host_active &&
      pin_code == sghbp_pkg::CODE_ADDR_B) |-> mode == sghbp_pkg::MODE_ADDRESS)
    else $error("address code not decoded");

  idle_float_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) mode == sghbp_pkg::MODE_INACTIVE |=> !bus_oe)
    else $error("bus driven in inactive mode");

  idle_regs_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) mode != sghbp_pkg::MODE_WRITE |=> $stable(regs_flat))
    else $error("register changed outside write mode");

  index_capture_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (mode == sghbp_pkg::MODE_ADDRESS && upper_match)
      |=> register_index == $past(index_candidate) && chip_selected)
    else $error("index not captured");

  index_refused_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (mode == sghbp_pkg::MODE_ADDRESS && !upper_match)
      |=> $stable(register_index) && !chip_selected)
    else $error("foreign index accepted");

  index_hold_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) mode != sghbp_pkg::MODE_ADDRESS
      |=> $stable(register_index))
    else $error("index changed outside address mode");

  write_store_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) write_enable
      |=> regs[$past(register_index)] == $past(bus_value))
    else $error("write data not stored");

  read_drive_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) pin_read |=> bus_oe && bus_out == $past(read_value))
    else $error("read data not driven");

  deselect_float_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) !chip_selected |=> !bus_oe)
    else $error("bus driven while deselected");

  reset_clear_a: assert property (@(posedge ref_clk)
    $rose(arst_n) |-> regs_flat == '0)
    else $error("registers not cleared by reset");

  host_ports_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (s_host_write &&
      s_host_addr == sghbp_pkg::SELECT_PORT_1)
      |-> host_mode == sghbp_pkg::MODE_ADDRESS)
    else $error("select port write not turned into address mode");

  port_a_read_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (host_read_hit &&
      register_index == sghbp_pkg::INDEX_PORT_A && !dir_a_out)
      |=> host_read_data == $past(s_port_a))
    else $error("port A pins not returned");

  port_dir_a: assert property (@(posedge ref_clk)
    disable iff (!arst_n) (write_enable &&
      register_index == sghbp_pkg::INDEX_MIXER_IO)
      |=> ##1 port_a_oe[0] == $past(bus_value[sghbp_pkg::DIR_A_BIT], 2) &&
              port_b_oe[7] == $past(bus_value[sghbp_pkg::DIR_B_BIT], 2))
    else $error("port direction not applied");

endmodule

/* shared/sghbp_pkg.sv */
/*
  Constants, encodings and mode type of the sound generator host bus port.
  Assumes nothing beyond a SystemVerilog compiler; imported by no file.
*/
package sghbp_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned INDEX_W   = 4;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned SYNC_W    = 48;

  // ---------------------------------------------------------------------
  // register array
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [3:0] INDEX_RESET    = 4'h0;
  localparam logic [3:0] INDEX_MIXER_IO = 4'h7;
  localparam logic [3:0] INDEX_PORT_A   = 4'hE;
  localparam logic [3:0] INDEX_PORT_B   = 4'hF;
  localparam int unsigned DIR_A_BIT     = 6;
  localparam int unsigned DIR_B_BIT     = 7;

  // ---------------------------------------------------------------------
  // chip select
  // ---------------------------------------------------------------------
  localparam logic [3:0] CHIP_UPPER       = 4'h0;
  localparam logic       UPPER_HIGH_MATCH = 1'b1;
  localparam logic       UPPER_LOW_MATCH  = 1'b0;

  // ---------------------------------------------------------------------
  // host i/o ports
  // ---------------------------------------------------------------------
  localparam logic [7:0] SELECT_PORT_0 = 8'hCF;
  localparam logic [7:0] SELECT_PORT_1 = 8'hDF;
  localparam logic [7:0] DATA_PORT_0   = 8'h0F;
  localparam logic [7:0] DATA_PORT_1   = 8'h1F;

  // ---------------------------------------------------------------------
  // bus control codes: direction, ctrl high, ctrl low
  // ---------------------------------------------------------------------
  localparam logic [2:0] CODE_IDLE   = 3'h0;
  localparam logic [2:0] CODE_ADDR_A = 3'h1;
  localparam logic [2:0] CODE_READ   = 3'h3;
  localparam logic [2:0] CODE_ADDR_B = 3'h4;
  localparam logic [2:0] CODE_WRITE  = 3'h6;
  localparam logic [2:0] CODE_ADDR_C = 3'h7;

  // ---------------------------------------------------------------------
  // reset values of control state
  // ---------------------------------------------------------------------
  localparam logic SELECT_RESET       = 1'b0;
  localparam logic DIVIDE_PHASE_RESET = 1'b0;
  localparam logic TICK_RESET         = 1'b0;

  typedef enum logic [1:0] {
    MODE_INACTIVE = 2'b00,
    MODE_ADDRESS  = 2'b01,
    MODE_WRITE    = 2'b11,
    MODE_READ     = 2'b10
  } sghbp_mode_type;

endpackage

/* testbench/sghbp_host_model.sv */
/*
  Host processor model: i/o port writes and reads on the board ports.
  Assumes the port takes host requests on rising edges of ref_clk.
*/
`timescale 1ns/1ps
module sghbp_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] host_read_data,
  output logic      [7:0] host_port_addr,
  output logic            host_write,
  output logic            host_read,
  output logic      [7:0] host_data
);
  // ---------------------------------------------------------------------
  // port cycles
  // ---------------------------------------------------------------------
  initial begin
    host_port_addr = 8'h00;
    host_write     = 1'b0;
    host_read      = 1'b0;
    host_data      = 8'h00;
  end

  // held five edges: the input sync plus register needs three
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_port_addr <= a;
    host_data      <= d;
    host_write     <= 1'b1;
    repeat (5) @(posedge ref_clk);
    host_write     <= 1'b0;
    host_port_addr <= 8'h00;
    host_data      <= ~d; // released lines no longer show the value
  endtask

  task automatic io_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    host_port_addr <= a;
    host_read      <= 1'b1;
    repeat (5) @(posedge ref_clk);
    d = host_read_data;
    host_read      <= 1'b0;
    host_port_addr <= 8'h00;
  endtask
endmodule

/* testbench/sghbp_top_bench.sv */
/*
  Self-checking bench of the host bus port: pin bus cycles, host i/o.
  Assumes the host model drives the host port and the bench the pins.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module sghbp_top_bench;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       bus_direction = 1'b0;
  logic       bus_ctrl_high = 1'b0;
  logic       bus_ctrl_low = 1'b0;
  logic [7:0] drv_bus = 8'h00;
  logic       upper_select_high = 1'b1;
  logic       upper_select_low = 1'b0;
  logic       clock_divide_select = 1'b1;
  logic [7:0] port_a_pins = 8'h00;
  logic [7:0] port_b_pins = 8'h00;
  logic [7:0] bus_in, bus_out, host_read_data, host_port_addr, host_data;
  logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, rd;
  logic [3:0] register_index, ticks;
  logic       bus_oe, master_tick, host_write, host_read;
  int         n_fail = 0;
  int         n_compared = 0;

  // ---------------------------------------------------------------------
  // clock, wire and instances
  // ---------------------------------------------------------------------
  always #2.5 ref_clk = ~ref_clk;
  assign bus_in = bus_oe ? bus_out : drv_bus;

  sghbp_top u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .bus_direction(bus_direction),
    .bus_ctrl_high(bus_ctrl_high), .bus_ctrl_low(bus_ctrl_low),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .upper_select_high(upper_select_high),
    .upper_select_low(upper_select_low),
    .clock_divide_select(clock_divide_select), .master_tick(master_tick),
    .port_a_pins(port_a_pins), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_b_pins(port_b_pins),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe),
    .host_port_addr(host_port_addr), .host_write(host_write),
    .host_read(host_read), .host_data(host_data),
    .host_read_data(host_read_data), .register_index(register_index));

  sghbp_host_model u_host (
    .ref_clk(ref_clk), .host_read_data(host_read_data),
    .host_port_addr(host_port_addr), .host_write(host_write),
    .host_read(host_read), .host_data(host_data));

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  // code held five edges; sync plus register needs three
  task automatic pin(input logic [2:0] c, input logic [7:0] b,
                     input logic hi = 1'b1, input logic lo = 1'b0);
    @(posedge ref_clk);
    {bus_direction, bus_ctrl_high, bus_ctrl_low} <= c;
    drv_bus           <= b;
    upper_select_high <= hi;
    upper_select_low  <= lo;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic count_ticks(input logic sel);
    @(posedge ref_clk);
    clock_divide_select <= sel;
    repeat (6) @(posedge ref_clk);
    ticks = 4'h0;
    repeat (8) begin
      @(posedge ref_clk);
      #1 ticks = ticks + {3'h0, master_tick};
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  initial begin
    logic [2:0] acode [3] = '{3'h1, 3'h4, 3'h7};
    logic [2:0] icode [3] = '{3'h0, 3'h2, 3'h5};
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(register_index, 4'h0)
    `CHK(bus_oe, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      pin(acode[i], {4'h0, 4'h9 + 4'(i)});
      `CHK(register_index, 4'h9 + 4'(i))
    end
    foreach (icode[i]) begin
      pin(icode[i], 8'h03);
      `CHK(register_index, 4'hB)
      `CHK(bus_oe, 1'b0)
    end
    $display("test mode decode done");
    pin(3'h1, 8'h03);
    pin(3'h6, 8'hA5);
    pin(3'h2, 8'h5A);
    pin(3'h3, 8'h00);
    `CHK(bus_oe, 1'b1)
    `CHK(bus_out, 8'hA5)
    `CHK(register_index, 4'h3)
    pin(3'h1, 8'h02);
    pin(3'h1, 8'h15);
    pin(3'h1, 8'h05, 1'b0, 1'b0);
    pin(3'h1, 8'h05, 1'b1, 1'b1);
    `CHK(register_index, 4'h2)
    pin(3'h6, 8'h77, 1'b1, 1'b1);
    pin(3'h3, 8'h00, 1'b1, 1'b1);
    `CHK(bus_oe, 1'b0)
    pin(3'h1, 8'h02);
    pin(3'h3, 8'h00);
    `CHK(bus_out, 8'h00)
    pin(3'h1, 8'h07);
    pin(3'h6, 8'h40);
    pin(3'h0, 8'h00);
    `CHK(port_a_oe, 8'hFF)
    `CHK(port_b_oe, 8'h00)
    $display("test pin bus done");
    for (int i = 0; i < 4; i++) begin
      u_host.io_write(i[0] ? 8'hDF : 8'hCF, 8'h01);
      u_host.io_write(i[1] ? 8'h1F : 8'h0F, 8'h10 + 8'(i));
      u_host.io_read(i[0] ? 8'hDF : 8'hCF, rd);
      `CHK(rd, 8'h10 + 8'(i))
    end
    u_host.io_write(8'hAF, 8'h05);
    `CHK(register_index, 4'h1)
    u_host.io_write(8'hCF, 8'h07);
    u_host.io_write(8'h0F, 8'h00);
    port_a_pins <= 8'h3C;
    u_host.io_write(8'hCF, 8'h0E);
    u_host.io_read(8'hCF, rd);
    `CHK(rd, 8'h3C)
    u_host.io_write(8'hCF, 8'h07);
    u_host.io_write(8'h1F, 8'hC0);
    u_host.io_write(8'hDF, 8'h0E);
    u_host.io_write(8'h0F, 8'h5A);
    `CHK(port_b_oe, 8'hFF)
    `CHK(port_a_out, 8'h5A)
    u_host.io_write(8'hCF, 8'h0F);
    u_host.io_write(8'h1F, 8'hA3);
    u_host.io_read(8'hCF, rd);
    `CHK(port_b_out, 8'hA3)
    `CHK(rd, 8'hA3)
    $display("test host port done");
    count_ticks(1'b1);
    `CHK(ticks, 4'h8)
    count_ticks(1'b0);
    `CHK(ticks, 4'h4)
    $display("test master clock done");
    @(posedge ref_clk) arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(port_a_oe, 8'h00)
    pin(3'h1, 8'h03);
    pin(3'h3, 8'h00);
    `CHK(bus_out, 8'h00)
    $display("test second reset done");
    summarize();
  end
endmodule
